// >>> hdl/epi_regs.vh
// constants for the encoder position interface
`ifndef EPI_REGS_VH
`define EPI_REGS_VH
`define EPI_POS_W 32
`define EPI_FRAME_W 25
`define EPI_LEN_SEL_13 2'h0
`define EPI_LEN_SEL_21 2'h1
`define EPI_LEN_SEL_25 2'h2
`define EPI_LEN_13 5'h0D
`define EPI_LEN_21 5'h15
`define EPI_LEN_25 5'h19
`define EPI_REV_BITS 5'h0C
`define EPI_SHIFT_HALF_NS 340
`define EPI_CLK_NS 10
`define EPI_SHIFT_HALF_CYC ((`EPI_SHIFT_HALF_NS + `EPI_CLK_NS - 1) / `EPI_CLK_NS)
`define EPI_MONO_NS 20000
`define EPI_MONO_CYC ((`EPI_MONO_NS + `EPI_CLK_NS - 1) / `EPI_CLK_NS)
`define EPI_LEAD_NS 1000
`define EPI_LEAD_CYC ((`EPI_LEAD_NS + `EPI_CLK_NS - 1) / `EPI_CLK_NS)
`define EPI_ST_IDLE 2'h0
`define EPI_ST_LOW 2'h1
`define EPI_ST_HIGH 2'h2
`define EPI_ST_MONO 2'h3
`endif

// >>> hdl/epi_sync.v
// two-flip-flop synchroniser, one per input bit
`timescale 1ns/1ps
`include "epi_regs.vh"
module epi_sync #(
	parameter W = 4
) (
	clk_sys,
	rst_b,
	asyncIn,
	syncOut
);
	input wire clk_sys;
	input wire rst_b;
	input wire [W-1:0] asyncIn;
	output wire [W-1:0] syncOut;
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : gBit
			reg meta_ff;
			reg stable_ff;
			always @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					meta_ff <= 1'b0;
					stable_ff <= 1'b0;
				end else begin
					meta_ff <= asyncIn[i];
					stable_ff <= meta_ff;
				end
			end
			assign syncOut[i] = stable_ff;
		end
	endgenerate
endmodule

// >>> hdl/epi_encoder_position_interface.v
// top of the per-axis encoder position interface: quadrature and serial absolute receiver
`timescale 1ns/1ps
`include "epi_regs.vh"
module epi_encoder_position_interface #(
	parameter MONO_CYC = `EPI_MONO_CYC
) (
	clk_sys,
	rst_b,
	modeAbsolute,
	fullProfile,
	lenSel,
	dataWidth,
	pulsesPerRev,
	leadEnable,
	servoTick,
	trackOne,
	trackOneN,
	trackTwo,
	trackTwoN,
	refMark,
	refMarkN,
	serData,
	serDataN,
	shiftClk,
	shiftClkN,
	positionValue,
	positionValid,
	refSeen,
	configError,
	frameBusy
);
	input wire clk_sys;
	input wire rst_b;
	input wire modeAbsolute;
	input wire fullProfile;
	input wire [1:0] lenSel;
	input wire [4:0] dataWidth;
	input wire [25:0] pulsesPerRev;
	input wire leadEnable;
	input wire servoTick;
	input wire trackOne;
	input wire trackOneN;
	input wire trackTwo;
	input wire trackTwoN;
	input wire refMark;
	input wire refMarkN;
	input wire serData;
	input wire serDataN;
	output reg shiftClk;
	output reg shiftClkN;
	output reg [`EPI_POS_W-1:0] positionValue;
	output reg positionValid;
	output reg refSeen;
	output reg configError;
	output reg frameBusy;

	wire [7:0] syncIn;
	wire aS;
	wire bS;
	wire zS;
	wire dS;
	// each wire of a pair is synced on its own; gating raw pins first lets pair skew glitch into the flops
	epi_sync #(.W(8)) uSync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.asyncIn({trackOne, trackOneN, trackTwo, trackTwoN, refMark, refMarkN, serData, serDataN}),
		.syncOut(syncIn)
	);
	// pair resolved after syncing: a skewed transition only passes through one level change
	assign aS = syncIn[7] & ~syncIn[6];
	assign bS = syncIn[5] & ~syncIn[4];
	assign zS = syncIn[3] & ~syncIn[2];
	assign dS = syncIn[1] & ~syncIn[0];

	reg aPrev_ff;
	reg bPrev_ff;
	reg zPrev_ff;
	reg [`EPI_POS_W-1:0] count_ff;
	reg [`EPI_POS_W-1:0] nxt_count;
	// gray decode needs only edge order, so any phase within 60..120 degrees is fine
	always @* begin
		nxt_count = count_ff;
		if ((aS ^ aPrev_ff) && !(bS ^ bPrev_ff)) begin
			if (aS ^ bS)
				nxt_count = count_ff + 32'h00000001;
			else
				nxt_count = count_ff - 32'h00000001;
		end else if ((bS ^ bPrev_ff) && !(aS ^ aPrev_ff)) begin
			if (aS ^ bS)
				nxt_count = count_ff - 32'h00000001;
			else
				nxt_count = count_ff + 32'h00000001;
		end
	end
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			aPrev_ff <= 1'b0;
			bPrev_ff <= 1'b0;
			zPrev_ff <= 1'b0;
			count_ff <= 32'h00000000;
		end else begin
			aPrev_ff <= aS;
			bPrev_ff <= bS;
			zPrev_ff <= zS;
			count_ff <= nxt_count;
		end
	end

	reg [4:0] frameLen;
	always @* begin
		case (lenSel)
			`EPI_LEN_SEL_13: frameLen = `EPI_LEN_13;
			`EPI_LEN_SEL_21: frameLen = `EPI_LEN_21;
			default: frameLen = `EPI_LEN_25;
		endcase
	end

	// digits needed for pulses per revolution (floor log2 for powers of two)
	reg [4:0] pprDigits;
	integer k;
	always @* begin
		pprDigits = 5'h00;
		for (k = 1; k < 26; k = k + 1) begin
			if (pulsesPerRev[k])
				pprDigits = k[4:0];
		end
	end
	wire [26:0] pprExt = {1'b0, pulsesPerRev};
	wire [4:0] fieldRem = frameLen - `EPI_REV_BITS;
	wire [26:0] limFir = 27'h0000001 << fieldRem;
	wire [26:0] limFull = 27'h0000001 << dataWidth;
	wire [5:0] widthLimFir = {1'b0, `EPI_REV_BITS} + {1'b0, pprDigits};
	reg cfgBad;
	always @* begin
		if (fullProfile) begin
			cfgBad = (dataWidth > frameLen) || (pprExt > limFull);
		end else begin
			cfgBad = (pprExt > limFir) || ({1'b0, dataWidth} > widthLimFir);
		end
	end

	reg [1:0] state_ff;
	reg [8:0] div_ff;
	reg [4:0] bitCnt_ff;
	reg [`EPI_FRAME_W-1:0] shift_ff;
	reg [15:0] mono_ff;
	reg [`EPI_POS_W-1:0] absPos_ff;
	reg startReq_ff;
	reg [8:0] lead_ff;
	reg leadArm_ff;
	wire halfDone = (div_ff == `EPI_SHIFT_HALF_CYC - 1);

	// frame result: field extraction keeps only the evaluated bits
	reg [`EPI_POS_W-1:0] frameVal;
	reg [`EPI_FRAME_W-1:0] aligned;
	always @* begin
		aligned = shift_ff;
		frameVal = 32'h00000000;
		if (fullProfile) begin
			aligned = shift_ff >> (frameLen - dataWidth);
			frameVal = {7'h00, aligned} & ~(32'hFFFFFFFF << dataWidth);
		end else begin
			// rev lsb clock 12, increment msb clock 13
			aligned = shift_ff >> (frameLen - widthLimFir[4:0]);
			frameVal = {7'h00, aligned} & ~(32'hFFFFFFFF << widthLimFir[4:0]);
		end
	end

	// optional lead time before the cycle instant
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lead_ff <= 9'h000;
			leadArm_ff <= 1'b0;
			startReq_ff <= 1'b0;
			positionValue <= 32'h00000000;
			positionValid <= 1'b0;
			refSeen <= 1'b0;
			configError <= 1'b0;
		end else begin
			positionValid <= 1'b0;
			startReq_ff <= 1'b0;
			configError <= modeAbsolute & cfgBad;
			if (zS && !zPrev_ff && !modeAbsolute)
				refSeen <= 1'b1;
			if (servoTick && leadEnable) begin
				leadArm_ff <= 1'b1;
				lead_ff <= 9'h000;
			end else if (leadArm_ff) begin
				lead_ff <= lead_ff + 9'h001;
				if (lead_ff == `EPI_LEAD_CYC - 1)
					leadArm_ff <= 1'b0;
			end
			// with lead enabled the tick marks the point one lead time ahead of the cycle instant
			if (servoTick && !leadEnable) begin
				positionValue <= modeAbsolute ? absPos_ff : count_ff;
				positionValid <= 1'b1;
				startReq_ff <= modeAbsolute;
			end else if (leadArm_ff && lead_ff == `EPI_LEAD_CYC - 1) begin
				positionValue <= modeAbsolute ? absPos_ff : count_ff;
				positionValid <= 1'b1;
				startReq_ff <= modeAbsolute;
			end
		end
	end

	// serial frame engine; the latched value is the previous frame, a one-cycle latency
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= `EPI_ST_IDLE;
			div_ff <= 9'h000;
			bitCnt_ff <= 5'h00;
			shift_ff <= 25'h0000000;
			mono_ff <= 16'h0000;
			absPos_ff <= 32'h00000000;
			shiftClk <= 1'b1;
			shiftClkN <= 1'b0;
			frameBusy <= 1'b0;
		end else begin
			case (state_ff)
				`EPI_ST_IDLE: begin
					shiftClk <= 1'b1;
					shiftClkN <= 1'b0;
					frameBusy <= 1'b0;
					div_ff <= 9'h000;
					// a bad configuration never starts a frame, so no wrong value is latched
					if (startReq_ff && !cfgBad) begin
						state_ff <= `EPI_ST_LOW;
						bitCnt_ff <= 5'h00;
						frameBusy <= 1'b1;
						shiftClk <= 1'b0;
						shiftClkN <= 1'b1;
					end
				end
				`EPI_ST_LOW: begin
					div_ff <= div_ff + 9'h001;
					if (halfDone) begin
						div_ff <= 9'h000;
						shiftClk <= 1'b1;
						shiftClkN <= 1'b0;
						state_ff <= `EPI_ST_HIGH;
					end
				end
				`EPI_ST_HIGH: begin
					div_ff <= div_ff + 9'h001;
					if (halfDone) begin
						div_ff <= 9'h000;
						// sample late in the high phase, after the encoder updated on the falling edge
						// only frameLen bits are shifted in
						shift_ff <= {shift_ff[`EPI_FRAME_W-2:0], dS};
						bitCnt_ff <= bitCnt_ff + 5'h01;
						if (bitCnt_ff == frameLen - 5'h01) begin
							state_ff <= `EPI_ST_MONO;
							mono_ff <= 16'h0000;
						end else begin
							shiftClk <= 1'b0;
							shiftClkN <= 1'b1;
							state_ff <= `EPI_ST_LOW;
						end
					end
				end
				`EPI_ST_MONO: begin
					absPos_ff <= frameVal;
					mono_ff <= mono_ff + 16'h0001;
					if (mono_ff == MONO_CYC[15:0] - 16'h0001) begin
						state_ff <= `EPI_ST_IDLE;
						frameBusy <= 1'b0;
					end
				end
				default: state_ff <= `EPI_ST_IDLE;
			endcase
		end
	end
endmodule

// >>> sim/epi_checker_sva.sv
// port assertions for the encoder position interface
`timescale 1ns/1ps
module epi_checker (
	input wire clk_sys,
	input wire rst_b,
	input wire modeAbsolute,
	input wire leadEnable,
	input wire servoTick,
	input wire shiftClk,
	input wire shiftClkN,
	input wire positionValid,
	input wire configError,
	input wire frameBusy
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_tick; !leadEnable && servoTick |-> ##[1:2] positionValid; endproperty
	a_tick: assert property (p_tick) else $error("no value");
	property p_lead; leadEnable && servoTick |-> ##[99:102] positionValid; endproperty
	a_lead: assert property (p_lead) else $error("no lead value");
	property p_spur; positionValid && !leadEnable |-> $past(servoTick) || $past(servoTick, 2); endproperty
	a_spur: assert property (p_spur) else $error("stray value");
	property p_idle; !frameBusy |-> shiftClk; endproperty
	a_idle: assert property (p_idle) else $error("clock not idle");
	property p_pair; shiftClkN == !shiftClk; endproperty
	a_pair: assert property (p_pair) else $error("clock pair");
	property p_quad; !modeAbsolute |=> !configError; endproperty
	a_quad: assert property (p_quad) else $error("quad error");
	property p_low; $fell(shiftClk) |-> (frameBusy && !shiftClk) [*8]; endproperty
	a_low: assert property (p_low) else $error("short low");
	property p_go; servoTick && modeAbsolute && !frameBusy && !configError && !leadEnable
		|-> ##[1:4] $fell(shiftClk); endproperty
	a_go: assert property (p_go) else $error("no frame");
endmodule
bind epi_encoder_position_interface epi_checker chk (.clk_sys, .rst_b, .modeAbsolute, .leadEnable,
	.servoTick, .shiftClk, .shiftClkN, .positionValid, .configError, .frameBusy);

// >>> sim/epi_ssi_encoder.sv
// serial absolute encoder model, msb first
`timescale 1ns/1ps
module epi_ssi_encoder (
	input wire logic shiftClk,
	input wire logic [24:0] word,
	output logic serData,
	output logic serDataN
);
	logic [24:0] sh;
	logic busy = 0;
	time tRise = 0;
	assign serDataN = ~serData;
	initial serData = 0;
	// one bit per clock, 25 at most
	always @(negedge shiftClk) begin
		if (!busy) sh = word;
		busy = 1;
		serData = sh[24];
		sh = sh << 1;
	end
	always @(posedge shiftClk) tRise = $time;
	// idle line toggles so a stale bit never passes for data
	always #170 begin
		if (busy && shiftClk && $time - tRise > 2000) busy = 0;
		if (!busy) serData = ~serData;
	end
endmodule

// >>> sim/epi_encoder_position_interface_bench.sv
// bench: quadrature count, lead latch, serial frames
`timescale 1ns/1ps
module epi_encoder_position_interface_bench;
	logic clk_sys = 0, rst_b = 0, modeAbsolute = 0, fullProfile = 0, leadEnable = 0;
	logic servoTick = 0, trackOne = 0, trackTwo = 0, refMark = 0, bad;
	logic [1:0] lenSel = 0;
	logic [4:0] dataWidth = 0;
	logic [25:0] pulsesPerRev = 0;
	logic [24:0] word = 0;
	logic [31:0] cnt = 0, prevAbs = 0, nv;
	logic [31:0] expQ[$];
	wire serData, serDataN, shiftClk, shiftClkN, positionValid, refSeen, configError, frameBusy;
	wire [31:0] positionValue;
	int errors = 0, comparisons = 0, ph = 0, n, l, dw, pp, f;
	int lens[4] = '{13, 21, 25, 25};
	int cfg[8][4] = '{'{2, 0, 16, 256}, '{1, 0, 16, 256}, '{0, 1, 12, 4096}, '{0, 0, 13, 4},
		'{2, 0, 21, 256}, '{0, 1, 14, 16}, '{2, 1, 10, 2048}, '{3, 1, 25, 1}};
	epi_encoder_position_interface #(.MONO_CYC(20)) uut (.clk_sys, .rst_b, .modeAbsolute, .fullProfile,
		.lenSel, .dataWidth, .pulsesPerRev, .leadEnable, .servoTick, .trackOne, .trackOneN(~trackOne),
		.trackTwo, .trackTwoN(~trackTwo), .refMark, .refMarkN(~refMark), .serData, .serDataN,
		.shiftClk, .shiftClkN, .positionValue, .positionValid, .refSeen, .configError, .frameBusy);
	epi_ssi_encoder enc (.shiftClk, .word, .serData, .serDataN);
	initial forever #5 clk_sys = ~clk_sys;
	task automatic check(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick(input logic [31:0] e);
		expQ.push_back(e);
		servoTick <= 1;
		@(posedge clk_sys) servoTick <= 0;
		repeat (120) @(posedge clk_sys);
	endtask
	// uneven spacing skews the track phase within limits
	task automatic step(input int d);
		ph = (ph + d) & 3;
		trackOne <= ph == 1 || ph == 2;
		trackTwo <= ph > 1;
		cnt += d;
		repeat (ph[0] ? 20 : 30) @(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		if (positionValid === 1'h1) begin
			if (expQ.size() == 0) check("stray value", 0, 1);
			else check("positionValue", expQ.pop_front(), positionValue);
		end
	end
	initial begin
		#1000000;
		errors++;
		report_and_stop;
	end
	initial begin
		void'($urandom(32'hBC9B));
		repeat (8) @(posedge clk_sys);
		rst_b <= 1;
		n = $urandom % 20 + 5;
		repeat (4 * n) step(1);
		tick(cnt);
		repeat (4 * n + 12) step(-1);
		leadEnable <= 1;
		refMark <= 1;
		tick(cnt);
		leadEnable <= 0;
		check("refSeen", 1, refSeen);
		modeAbsolute <= 1;
		foreach (cfg[i]) begin
			lenSel <= cfg[i][0];
			fullProfile <= cfg[i][1];
			dataWidth <= cfg[i][2];
			pulsesPerRev <= cfg[i][3];
			word <= 25'($urandom);
			repeat (5) @(posedge clk_sys);
			l = lens[cfg[i][0]];
			dw = cfg[i][2];
			pp = cfg[i][3];
			f = cfg[i][1] ? dw : 11 + $clog2(pp + 1);
			bad = cfg[i][1] ? dw > l || pp > 2 ** dw : pp > 2 ** (l - 12) || dw > f;
			nv = 32'(word >> (25 - f));
			check("configError", bad, configError);
			tick(prevAbs);
			if (!bad) prevAbs = nv;
			repeat (2400) @(posedge clk_sys);
		end
		tick(prevAbs);
		report_and_stop;
	end
endmodule
